// ==== rtl/nibble_core.sv ====
// Control and register-transfer core of the nibble controller
`timescale 1ns/1ps
// Contract
// [RULE1] Four identical return entries allow subroutine nesting four deep.
// [RULE2] Table fetch holds one stack entry while running, leaving three levels.
// [RULE3] Beyond four pushes, older return addresses are overwritten silently.
// [RULE4] After back-up, pointers, page-low and hold byte are undefined.
// [RULE5] Software reloads pointers, page-low and hold byte after back-up.
// [RULE6] Skip fetches next instruction but squashes it; cycle count unchanged.
// [RULE7] Skipped table fetch or return takes exactly one cycle.
// [RULE8] Data pointer is X (2 bits) above Y (4 bits).
// [RULE9] Memory operands use the word addressed by the data pointer.
// [RULE10] Program counter is 4-bit page over 7-bit offset, independently loadable.
// [RULE11] Each stack entry holds 11 bits, chosen by a 2-bit pointer.
// [RULE12] Table fetch pushes, jumps, loads B and A from ROM, returns.
// [RULE13] With top bit enable set, table fetch copies ROM bit 8 to carry.
// [RULE14] Stack pointer wraps modulo four both ways.
// [RULE15] Back-up entry sets stack pointer to binary 11.
module nibble_core
	import nibble_core_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic backup_entry,
	input wire logic cmd_valid,
	input wire cmd_t cmd,
	input wire logic [ROM_W-1:0] rom_data,
	output logic cmd_ready,
	output logic [PC_W-1:0] pc,
	output logic [PC_W-1:0] rom_addr,
	output logic [DP_W-1:0] data_pointer,
	output work_t work,
	output logic [SP_W-1:0] stack_ptr,
	output logic [7:0] table_hold_byte,
	output logic [2:0] page_low_ptr,
	output logic top_rom_bit_enable
);
	typedef enum logic [1:0] {S_RUN, S_TABLE_READ, S_TABLE_RET} state_t;

	state_t state;
	logic skip_pending;
	logic [1:0] x_reg;
	logic [3:0] y_reg;
	logic squash;
	logic take;
	logic push;
	logic pop;
	logic [PC_W-1:0] top_value;
	logic [SP_W-1:0] sp;

	// ---------------------------------------
	// Instruction acceptance
	// ---------------------------------------
	assign take = cmd_valid && cmd_ready;
	assign squash = take && skip_pending; // see [RULE6]
	assign push = (take && !squash && (cmd.op == OP_CALL || cmd.op == OP_TABLE)); // see [RULE2]
	assign pop = (take && !squash && (cmd.op == OP_RETURN || cmd.op == OP_RETURN_SKIP))
		|| state == S_TABLE_RET; // see [RULE12]

	return_stack #(
		.DEPTH(STACK_DEPTH)
	) u_stack (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.init(backup_entry),
		.push(push),
		.pop(pop),
		.push_value(pc),
		.top_value(top_value),
		.sp(sp)
	); // see [RULE1] see [RULE11]

	assign stack_ptr = sp;

	// ---------------------------------------
	// Sequencer
	// ---------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (!resetn || backup_entry)
			state <= S_RUN;
		else
		begin
			unique case (state)
				S_RUN:
					if (take && !squash && cmd.op == OP_TABLE)
						state <= S_TABLE_READ; // see [RULE12]
				S_TABLE_READ:
					state <= S_TABLE_RET;
				S_TABLE_RET:
					state <= S_RUN;
			endcase
		end
	end

	// Stall during the extra table cycles; a skipped one never gets here
	always_ff @(posedge clk_sys)
	begin
		if (!resetn || backup_entry)
			cmd_ready <= 1'b1;
		else if (take && !squash && cmd.op == OP_TABLE)
			cmd_ready <= 1'b0; // see [RULE7]
		else if (state == S_TABLE_RET)
			cmd_ready <= 1'b1;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn || backup_entry)
			skip_pending <= 1'b0;
		else if (take)
			skip_pending <= !squash && (cmd.op == OP_SKIP || cmd.op == OP_RETURN_SKIP); // see [RULE6]
	end

	// ---------------------------------------
	// Program counter
	// ---------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (!resetn || backup_entry)
			pc <= PC_RESET;
		else if (state == S_TABLE_RET)
			pc <= top_value; // see [RULE12]
		else if (take)
		begin
			if (squash)
				pc <= pc + 11'h1; // see [RULE6] see [RULE7]
			else
			begin
				unique case (cmd.op)
					OP_LOAD_PAGE: pc <= {cmd.page, pc[OFFS_W-1:0]}; // see [RULE10]
					OP_LOAD_OFFSET: pc <= {pc[PC_W-1:OFFS_W], cmd.offset}; // see [RULE10]
					OP_JUMP, OP_CALL: pc <= {cmd.page, cmd.offset};
					OP_TABLE: pc <= {cmd.page, page_low_ptr, work.acc}; // see [RULE12]
					OP_RETURN, OP_RETURN_SKIP: pc <= top_value;
					default: pc <= pc + 11'h1;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn || backup_entry)
			rom_addr <= PC_RESET;
		else if (take && !squash && cmd.op == OP_TABLE)
			rom_addr <= {cmd.page, page_low_ptr, work.acc}; // see [RULE12]
	end

	// ---------------------------------------
	// Working registers
	// ---------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (!resetn || backup_entry)
			work <= '{acc: NIB_RESET, b_reg: NIB_RESET, carry_flag: 1'b0};
		else if (state == S_TABLE_READ)
		begin
			work.b_reg <= rom_data[7:4]; // see [RULE12]
			work.acc <= rom_data[3:0]; // see [RULE12]
			if (top_rom_bit_enable)
				work.carry_flag <= rom_data[ROM_TOP_BIT]; // see [RULE13]
		end
		else if (take && !squash && cmd.op == OP_LOAD_HOLD)
			work.acc <= cmd.data;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn || backup_entry)
			top_rom_bit_enable <= 1'b0;
		else if (take && !squash && cmd.op == OP_SET_TOP)
			top_rom_bit_enable <= 1'b1;
	end

	// Back-up leaves these untouched, so their content is unspecified for software
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			x_reg <= 2'h0;
			y_reg <= 4'h0;
			page_low_ptr <= 3'h0;
			table_hold_byte <= 8'h00;
		end
		else if (take && !squash) // see [RULE4] see [RULE5]
		begin
			if (cmd.op == OP_LOAD_XY)
			begin
				x_reg <= cmd.data[1:0];
				y_reg <= cmd.byte_data[3:0];
			end
			if (cmd.op == OP_LOAD_PAGE_LOW)
				page_low_ptr <= cmd.data[2:0];
			if (cmd.op == OP_LOAD_HOLD)
				table_hold_byte <= cmd.byte_data;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			data_pointer <= 6'h00;
		else
			data_pointer <= {x_reg, y_reg}; // see [RULE8] see [RULE9]
	end

	// ---------------------------------------
	// Checks
	// ---------------------------------------
	a_skip_squash: assert property (@(posedge clk_sys) disable iff (!resetn || backup_entry)
		squash |=> pc == $past(pc) + 11'h1 && cmd_ready) else $error("squashed op not single cycle"); // see [RULE7]
	a_table_len: assert property (@(posedge clk_sys) disable iff (!resetn || backup_entry)
		take && !squash && cmd.op == OP_TABLE |=> !cmd_ready ##1 !cmd_ready ##1 cmd_ready)
		else $error("table fetch length wrong"); // see [RULE12]
	a_table_return: assert property (@(posedge clk_sys) disable iff (!resetn || backup_entry)
		take && !squash && cmd.op == OP_TABLE |=> ##2 pc == $past(pc, 3)) else $error("table did not return"); // see [RULE2]
	a_table_load: assert property (@(posedge clk_sys) disable iff (!resetn || backup_entry)
		state == S_TABLE_READ |=> work.acc == $past(rom_data[3:0]) && work.b_reg == $past(rom_data[7:4]))
		else $error("table data not loaded"); // see [RULE12]
	a_carry_hold: assert property (@(posedge clk_sys) disable iff (!resetn || backup_entry)
		state == S_TABLE_READ && !top_rom_bit_enable |=> $stable(work.carry_flag))
		else $error("carry changed without enable"); // see [RULE13]
	a_carry_copy: assert property (@(posedge clk_sys) disable iff (!resetn || backup_entry)
		state == S_TABLE_READ && top_rom_bit_enable |=> work.carry_flag == $past(rom_data[8]))
		else $error("carry not copied"); // see [RULE13]
	a_backup_sp: assert property (@(posedge clk_sys) disable iff (!resetn)
		backup_entry |=> stack_ptr == 2'h3 && pc == 11'h000) else $error("back-up init wrong"); // see [RULE15]
	a_dp_form: assert property (@(posedge clk_sys) disable iff (!resetn)
		take && !squash && cmd.op == OP_LOAD_XY && !backup_entry |=> ##1 data_pointer == {$past(cmd.data[1:0], 2),
		$past(cmd.byte_data[3:0], 2)}) else $error("data pointer form wrong"); // see [RULE8]
endmodule : nibble_core

// ==== rtl/nibble_core_pkg.sv ====
// Package: widths, reset values and carriers for the nibble controller core
package nibble_core_pkg;
	localparam int PC_W = 11;
	localparam int PAGE_W = 4;
	localparam int OFFS_W = 7;
	localparam int SP_W = 2;
	localparam int STACK_DEPTH = 4;
	localparam int ROM_W = 9;
	localparam int DP_W = 6;
	localparam logic [SP_W-1:0] SP_RESET = 2'h3;
	localparam logic [PC_W-1:0] PC_RESET = 11'h000;
	localparam logic [3:0] NIB_RESET = 4'h0;
	localparam int ROM_TOP_BIT = 8;

	typedef enum logic [3:0] {
		OP_NONE,
		OP_LOAD_PAGE,
		OP_LOAD_OFFSET,
		OP_JUMP,
		OP_CALL,
		OP_RETURN,
		OP_RETURN_SKIP,
		OP_TABLE,
		OP_LOAD_XY,
		OP_LOAD_PAGE_LOW,
		OP_LOAD_HOLD,
		OP_SET_TOP,
		OP_SKIP
	} op_t;

	typedef struct packed {
		op_t op;
		logic [PAGE_W-1:0] page;
		logic [OFFS_W-1:0] offset;
		logic [3:0] data;
		logic [7:0] byte_data;
	} cmd_t;

	typedef struct packed {
		logic [3:0] acc;
		logic [3:0] b_reg;
		logic carry_flag;
	} work_t;
endpackage : nibble_core_pkg

// ==== rtl/return_stack.sv ====
// Four-entry return stack with wrapping pointer
`timescale 1ns/1ps
module return_stack
	import nibble_core_pkg::*;
#(
	parameter int DEPTH = STACK_DEPTH
)(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic init,
	input wire logic push,
	input wire logic pop,
	input wire logic [PC_W-1:0] push_value,
	output logic [PC_W-1:0] top_value,
	output logic [SP_W-1:0] sp
);
	// Pointer arithmetic wraps at the pointer width, so depth must match it
	if (DEPTH != (1 << SP_W))
	begin : g_depth_check
		$error("return_stack depth must match pointer width");
	end

	logic [PC_W-1:0] entry [DEPTH];

	// ---------------------------------------
	// Pointer
	// ---------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (!resetn || init)
			sp <= SP_RESET; // see [RULE15]
		else if (push)
			sp <= sp + 2'h1; // see [RULE14]
		else if (pop)
			sp <= sp - 2'h1; // see [RULE14]
	end

	// ---------------------------------------
	// Entries
	// ---------------------------------------
	// No overflow guard: a fifth push lands on the oldest entry
	always_ff @(posedge clk_sys)
	begin
		if (push)
			entry[sp + 2'h1] <= push_value; // see [RULE3]
	end

	assign top_value = entry[sp];

	a_wrap_push: assert property (@(posedge clk_sys) disable iff (!resetn)
		push && !init |=> sp == $past(sp) + 2'h1) else $error("stack pointer did not advance"); // see [RULE14]
	a_pop_back: assert property (@(posedge clk_sys) disable iff (!resetn)
		pop && !push && !init |=> sp == $past(sp) - 2'h1) else $error("stack pointer did not retreat"); // see [RULE14]
endmodule : return_stack

// ==== dv/rom_model.sv ====
// Program ROM model for table fetches
`timescale 1ns/1ps
module rom_model
	import nibble_core_pkg::*;
(
	input wire logic [PC_W-1:0] rom_addr,
	output logic [ROM_W-1:0] rom_data
);
	// Every bit follows the address, so a wrong target shows
	assign rom_data = {rom_addr[0] ^ rom_addr[5], rom_addr[7:0] ^ rom_addr[10:3]};
endmodule : rom_model

// ==== dv/tb.sv ====
// Self-checking bench for the nibble core
`timescale 1ns/1ps
module tb
	import nibble_core_pkg::*;
;
	typedef struct packed {
		logic f;
		logic u;
		logic [PC_W-1:0] pc;
		logic [PC_W-1:0] ra;
		logic [SP_W-1:0] sp;
		logic [DP_W-1:0] dp;
		work_t w;
		logic [7:0] er;
		logic [2:0] dr;
		logic [1:0] cy;
	} note_t;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic backup_entry = 1'b0;
	logic cmd_valid = 1'b0;
	cmd_t cmd = '0;
	logic [ROM_W-1:0] rom_data;
	logic cmd_ready;
	logic [PC_W-1:0] pc;
	logic [PC_W-1:0] rom_addr;
	logic [DP_W-1:0] data_pointer;
	work_t work;
	logic [SP_W-1:0] stack_ptr;
	logic [7:0] table_hold_byte;
	logic [2:0] page_low_ptr;
	logic top_rom_bit_enable;
	logic [PC_W-1:0] stk [STACK_DEPTH];
	note_t m;
	note_t e;
	note_t q[$];
	logic sk = 1'b0;
	logic [1:0] seen;
	int n_errors = 0;
	int n_compared = 0;
	int seed = 32'hba78;
	int cycles = 0;
	event ev;
	nibble_core dut_u (.clk_sys(clk_sys), .resetn(resetn), .backup_entry(backup_entry), .cmd_valid(cmd_valid),
		.cmd(cmd), .rom_data(rom_data), .cmd_ready(cmd_ready), .pc(pc), .rom_addr(rom_addr),
		.data_pointer(data_pointer), .work(work), .stack_ptr(stack_ptr), .table_hold_byte(table_hold_byte),
		.page_low_ptr(page_low_ptr), .top_rom_bit_enable(top_rom_bit_enable));
	rom_model rom_u (.rom_addr(rom_addr), .rom_data(rom_data));
	initial
		forever #5 clk_sys = ~clk_sys;
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test
	// Hang guard, well above the roughly 120 cycles needed
	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			n_errors++;
			finish_test();
		end
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
		n_compared++;
		if (s !== x)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", n, x, s);
		end
	endtask : chk
	always
	begin
		@(ev);
		e = q.pop_front();
		chk("pc", pc, e.pc);
		chk("sp", stack_ptr, e.sp);
		chk("work", work, e.w);
		chk("top_en", top_rom_bit_enable, e.u);
		chk("cycles", seen, e.cy);
		if (e.f)
		begin
			chk("rom_addr", rom_addr, e.ra);
			chk("hold", table_hold_byte, e.er);
			chk("page_low", page_low_ptr, e.dr);
			// Pointer output trails X and Y by one clock
			@(posedge clk_sys);
			#1;
			chk("dp", data_pointer, e.dp);
		end
	end
	task automatic note();
		q.push_back(m);
		->ev;
	endtask : note
	task automatic op(input op_t o, input logic [3:0] pg, input logic [6:0] of, input logic [3:0] d,
		input logic [7:0] b);
		logic [ROM_W-1:0] r;
		m.cy = 2'h0;
		if (sk)
		begin
			m.pc = m.pc + 11'h001;
			sk = 1'b0;
		end
		else
			case (o)
				OP_LOAD_PAGE: m.pc[10:7] = pg;
				OP_LOAD_OFFSET: m.pc[6:0] = of;
				OP_JUMP: m.pc = {pg, of};
				OP_CALL:
				begin
					m.sp = m.sp + 2'h1;
					stk[m.sp] = m.pc;
					m.pc = {pg, of};
				end
				OP_RETURN, OP_RETURN_SKIP:
				begin
					m.pc = stk[m.sp];
					m.sp = m.sp - 2'h1;
					sk = (o == OP_RETURN_SKIP);
				end
				OP_TABLE:
				begin
					m.cy = 2'h2;
					stk[2'(m.sp + 2'h1)] = m.pc;
					m.ra = {pg, m.dr, m.w.acc};
					r = {m.ra[0] ^ m.ra[5], m.ra[7:0] ^ m.ra[10:3]};
					{m.w.b_reg, m.w.acc} = r[7:0];
					if (m.u)
						m.w.carry_flag = r[8];
				end
				default:
				begin
					m.pc = m.pc + 11'h001;
					sk = (o == OP_SKIP);
					if (o == OP_LOAD_XY)
						m.dp = {d[1:0], b[3:0]};
					if (o == OP_LOAD_PAGE_LOW)
						m.dr = d[2:0];
					if (o == OP_SET_TOP)
						m.u = 1'b1;
					if (o == OP_LOAD_HOLD)
						{m.er, m.w.acc} = {b, d};
				end
			endcase
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd <= '{o, pg, of, d, b};
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
		#1;
		seen = 2'h0;
		while (cmd_ready !== 1'b1 && seen < 2'h3)
		begin
			@(posedge clk_sys);
			#1;
			seen++;
		end
		note();
	endtask : op
	task automatic done(input string s);
		$display("test %s done", s);
	endtask : done
	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	initial
	begin
		m = '0;
		m.sp = SP_RESET;
		m.f = 1'b1;
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		#1;
		seen = 2'h0;
		note();
		repeat (4)
		begin
			op(OP_LOAD_XY, 4'h0, 7'h00, 4'($random(seed)), 8'($random(seed)));
			op(OP_LOAD_PAGE_LOW, 4'h0, 7'h00, 4'($random(seed)), 8'h00);
			op(OP_LOAD_HOLD, 4'h0, 7'h00, 4'($random(seed)), 8'($random(seed)));
		end
		op(OP_LOAD_PAGE, 4'h5, 7'h00, 4'h0, 8'h00);
		op(OP_LOAD_OFFSET, 4'h0, 7'h7f, 4'h0, 8'h00);
		op(OP_JUMP, 4'hf, 7'h7f, 4'h0, 8'h00);
		op(OP_NONE, 4'h0, 7'h00, 4'h0, 8'h00);
		done("loads");
		// Five deep: the fifth push lands on the first entry
		for (int i = 0; i < 10; i++)
			op(i < 5 ? OP_CALL : OP_RETURN, 4'(i), 7'(i * 9), 4'h0, 8'h00);
		done("stack");
		for (int i = 0; i < 3; i++)
			op(OP_CALL, 4'h2, 7'(i), 4'h0, 8'h00);
		op(OP_TABLE, 4'h9, 7'h00, 4'h0, 8'h00);
		op(OP_SET_TOP, 4'h0, 7'h00, 4'h0, 8'h00);
		op(OP_TABLE, 4'h6, 7'h00, 4'h0, 8'h00);
		op(OP_TABLE, 4'h1, 7'h00, 4'h0, 8'h00);
		for (int i = 0; i < 3; i++)
			op(OP_RETURN, 4'h0, 7'h00, 4'h0, 8'h00);
		done("table");
		op(OP_SKIP, 4'h0, 7'h00, 4'h0, 8'h00);
		op(OP_JUMP, 4'h7, 7'h11, 4'h0, 8'h00);
		op(OP_CALL, 4'h3, 7'h22, 4'h0, 8'h00);
		op(OP_RETURN_SKIP, 4'h0, 7'h00, 4'h0, 8'h00);
		op(OP_TABLE, 4'h4, 7'h00, 4'h0, 8'h00);
		op(OP_SKIP, 4'h0, 7'h00, 4'h0, 8'h00);
		op(OP_RETURN, 4'h0, 7'h00, 4'h0, 8'h00);
		op(OP_SKIP, 4'h0, 7'h00, 4'h0, 8'h00);
		op(OP_CALL, 4'h8, 7'h05, 4'h0, 8'h00);
		done("skip");
		@(posedge clk_sys);
		backup_entry <= 1'b1;
		@(posedge clk_sys);
		backup_entry <= 1'b0;
		#1;
		{m.pc, m.sp, m.w, m.u, m.f, m.cy, sk} = {PC_RESET, SP_RESET, 9'h000, 5'h00};
		note();
		op(OP_LOAD_XY, 4'h0, 7'h00, 4'h2, 8'h0b);
		op(OP_LOAD_PAGE_LOW, 4'h0, 7'h00, 4'h5, 8'h00);
		op(OP_LOAD_HOLD, 4'h0, 7'h00, 4'hc, 8'ha7);
		op(OP_TABLE, 4'h2, 7'h00, 4'h0, 8'h00);
		m.f = 1'b1;
		op(OP_NONE, 4'h0, 7'h00, 4'h0, 8'h00);
		done("backup");
		// Let the trailing pointer check of the last note run
		repeat (2) @(posedge clk_sys);
		finish_test();
	end
endmodule : tb
